/* rtl/axpc_axis_pulse_position_control.sv */
// Purpose: one motion axis: pulse generator, position counters, compare
// Assumes: clk_i at axpc_pkg::CLK_HZ, encoder pins asynchronous
// Notes:   speed ramps are linear per pulse; the S-curve bit is stored only
`default_nettype none
module axpc_axis_pulse_position_control #(
    parameter int unsigned SPD_W = 14,
    parameter int unsigned RNG_W = 24
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        enc_a_i,
    input  wire logic        enc_b_i,
    output logic             pulse_pos_o,
    output logic             pulse_neg_o,
    output logic             dir_neg_o,
    output logic             driving_o
);
    // Accumulator must hold speed and range products without overflow
    localparam int unsigned ACC_W = 56;

    // Wider fields would overflow the phase accumulator
    if (SPD_W < 1 || SPD_W > 16 || RNG_W < 1 || RNG_W > 24) begin : g_bad_width
        $error("Unsupported width");
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Bus slave
    // One wait state: ack follows the request by a cycle
    logic        ack_reg;
    logic [31:0] rdat_reg;
    logic        wr_go;
    logic        rd_go;
    assign wr_go = ce_i & wb_cyc_i & wb_stb_i & ~ack_reg & wb_we_i;
    assign rd_go = ce_i & wb_cyc_i & wb_stb_i & ~ack_reg & ~wb_we_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else if (ce_i) begin
            ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

    function automatic logic hit(input logic [7:0] ofs);
        return wr_go && wb_adr_i == ofs;
    endfunction

    axpc_pkg::axpc_wr2_t wr2_reg;
    axpc_pkg::axpc_wr3_t wr3_reg;
    logic [31:0] range_reg, speed_reg, init_reg, acc_reg, dec_reg;
    logic [31:0] pulses_reg, dp_reg, cmpu_reg, cmpl_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr2_reg    <= axpc_pkg::RST_ZERO;
            wr3_reg    <= axpc_pkg::RST_ZERO;
            range_reg  <= axpc_pkg::RST_RANGE;
            speed_reg  <= axpc_pkg::RST_ZERO;
            init_reg   <= axpc_pkg::RST_ZERO;
            acc_reg    <= axpc_pkg::RST_RATE;
            dec_reg    <= axpc_pkg::RST_RATE;
            pulses_reg <= axpc_pkg::RST_ZERO;
            dp_reg     <= axpc_pkg::RST_ZERO;
            cmpu_reg   <= axpc_pkg::RST_ZERO;
            cmpl_reg   <= axpc_pkg::RST_ZERO;
        end else begin
            if (hit(axpc_pkg::OFS_WR2)) wr2_reg <= merge(wr2_reg, wb_dat_i, wb_sel_i);
            if (hit(axpc_pkg::OFS_WR3)) wr3_reg <= merge(wr3_reg, wb_dat_i, wb_sel_i);
            if (hit(axpc_pkg::OFS_RANGE)) range_reg <= merge(range_reg, wb_dat_i, wb_sel_i);
            if (hit(axpc_pkg::OFS_SPEED)) speed_reg <= merge(speed_reg, wb_dat_i, wb_sel_i);
            if (hit(axpc_pkg::OFS_INIT)) init_reg <= merge(init_reg, wb_dat_i, wb_sel_i);
            if (hit(axpc_pkg::OFS_ACC)) acc_reg <= merge(acc_reg, wb_dat_i, wb_sel_i);
            if (hit(axpc_pkg::OFS_DEC)) dec_reg <= merge(dec_reg, wb_dat_i, wb_sel_i);
            if (hit(axpc_pkg::OFS_PULSES)) pulses_reg <= merge(pulses_reg, wb_dat_i, wb_sel_i);
            if (hit(axpc_pkg::OFS_DP)) dp_reg <= merge(dp_reg, wb_dat_i, wb_sel_i);
            if (hit(axpc_pkg::OFS_CMPU)) cmpu_reg <= merge(cmpu_reg, wb_dat_i, wb_sel_i);
            if (hit(axpc_pkg::OFS_CMPL)) cmpl_reg <= merge(cmpl_reg, wb_dat_i, wb_sel_i);
        end
    end

    logic sclk_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_reg <= 1'b0;
        end else if (ce_i) begin
            sclk_reg <= ~sclk_reg;
        end
    end

    // Encoder synchroniser; stage one feeds only stage two
    logic [1:0] ea_reg, eb_reg;
    logic       ea_d_reg, eb_d_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ea_reg   <= 2'h0;
            eb_reg   <= 2'h0;
            ea_d_reg <= 1'b0;
            eb_d_reg <= 1'b0;
        end else if (ce_i) begin
            ea_reg   <= {ea_reg[0], enc_a_i};
            eb_reg   <= {eb_reg[0], enc_b_i};
            ea_d_reg <= ea_reg[1];
            eb_d_reg <= eb_reg[1];
        end
    end

    logic enc_up, enc_dn;
    always_comb begin
        enc_up = 1'b0;
        enc_dn = 1'b0;
        if (wr2_reg.enc_updown) begin
            enc_up = ea_reg[1] & ~ea_d_reg;
            enc_dn = eb_reg[1] & ~eb_d_reg;
        end else if ((ea_reg[1] ^ ea_d_reg) ^ (eb_reg[1] ^ eb_d_reg)) begin
            enc_up = (ea_reg[1] ^ ea_d_reg) ? (ea_reg[1] ^ eb_reg[1]) : (ea_reg[1] ~^ eb_reg[1]);
            enc_dn = ~enc_up;
        end
    end

    logic signed [31:0] lpos_reg, rpos_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rpos_reg <= axpc_pkg::RST_ZERO;
        end else if (hit(axpc_pkg::OFS_RPOS)) begin
            rpos_reg <= merge(rpos_reg, wb_dat_i, wb_sel_i);
        end else if (ce_i && enc_up) begin
            rpos_reg <= rpos_reg + 32'sd1;
        end else if (ce_i && enc_dn) begin
            rpos_reg <= rpos_reg - 32'sd1;
        end
    end

    logic signed [31:0] cmp_pos;
    logic above, below;
    assign cmp_pos = wr2_reg.compare_source_select ? rpos_reg : lpos_reg;
    assign above = cmp_pos > $signed(cmpu_reg);
    assign below = cmp_pos < $signed(cmpl_reg);

    // Flags registered so the bus sees a settled level
    logic [1:0] rr1_reg, rr2_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rr1_reg <= 2'h0;
            rr2_reg <= 2'h0;
        end else if (ce_i) begin
            rr1_reg <= {below, above};
            rr2_reg <= {below & wr2_reg.lim_neg_en, above & wr2_reg.lim_pos_en};
        end
    end

    // Pulse engine
    axpc_pkg::axpc_state_t state_reg;
    logic [ACC_W-1:0] phase_reg;
    logic [SPD_W-1:0] spd_reg;
    logic [31:0]      cnt_reg, upcnt_reg;
    logic             lvl_reg, neg_reg, cont_reg, stop_reg;
    logic [ACC_W-1:0] inc, thr, sum;
    logic             tog;
    logic [SPD_W:0]   up_spd, dn_spd;
    logic [SPD_W-1:0] step_dn;
    logic             lim_hit, go_decel;

    // rate = speed * 8e6 / range, via cross-multiplied threshold
    assign inc = ACC_W'(spd_reg) * ACC_W'(2 * axpc_pkg::MULT_NUM);
    assign thr = ACC_W'(range_reg[RNG_W-1:0]) * ACC_W'(axpc_pkg::SCLK_HZ);
    assign sum = phase_reg + inc;
    // remainder carried, so periods interleave two lengths
    assign tog = ce_i & sclk_reg & (state_reg != axpc_pkg::ST_IDLE) & (sum >= thr);

    assign step_dn = wr3_reg.sep_decel ? dec_reg[SPD_W-1:0] : acc_reg[SPD_W-1:0];
    assign up_spd  = {1'b0, spd_reg} + {1'b0, acc_reg[SPD_W-1:0]};
    assign dn_spd  = {1'b0, spd_reg} - {1'b0, step_dn};
    assign lim_hit = neg_reg ? rr2_reg[1] : rr2_reg[0];
    assign go_decel = stop_reg | lim_hit |
        (~cont_reg & (wr3_reg.manual_decel ? (cnt_reg >= dp_reg)
                                            : (pulses_reg - cnt_reg <= upcnt_reg)));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= axpc_pkg::ST_IDLE;
            phase_reg <= '0;
            spd_reg   <= '0;
            cnt_reg   <= axpc_pkg::RST_ZERO;
            upcnt_reg <= axpc_pkg::RST_ZERO;
            lvl_reg   <= 1'b0;
            neg_reg   <= 1'b0;
            cont_reg  <= 1'b0;
            stop_reg  <= 1'b0;
        end else if (ce_i) begin
            if (hit(axpc_pkg::OFS_CMD) && wb_dat_i[axpc_pkg::CMD_STOP]) begin
                stop_reg <= 1'b1;
            end
            if (state_reg == axpc_pkg::ST_IDLE) begin
                if (hit(axpc_pkg::OFS_CMD) && wb_dat_i[axpc_pkg::CMD_START]
                    && range_reg != axpc_pkg::RST_ZERO) begin
                    state_reg <= axpc_pkg::ST_ACCEL;
                    neg_reg   <= wb_dat_i[axpc_pkg::CMD_NEG];
                    cont_reg  <= wb_dat_i[axpc_pkg::CMD_CONT];
                    stop_reg  <= 1'b0;
                    spd_reg   <= init_reg[SPD_W-1:0];
                    phase_reg <= '0;
                    cnt_reg   <= axpc_pkg::RST_ZERO;
                    upcnt_reg <= axpc_pkg::RST_ZERO;
                end
            end else if (tog) begin
                // edges land on system clock ticks
                phase_reg <= sum - thr;
                lvl_reg   <= ~lvl_reg;
                if (!lvl_reg) begin
                    cnt_reg <= cnt_reg + 32'd1;
                end else if (!cont_reg && cnt_reg >= pulses_reg) begin
                    state_reg <= axpc_pkg::ST_IDLE;
                end else begin
                    // speed changes at falling edge, so low phase differs
                    case (state_reg)
                        axpc_pkg::ST_ACCEL: begin
                            upcnt_reg <= upcnt_reg + 32'd1;
                            if (go_decel) begin
                                state_reg <= axpc_pkg::ST_DECEL;
                            end else if (up_spd >= {1'b0, speed_reg[SPD_W-1:0]}) begin
                                spd_reg   <= speed_reg[SPD_W-1:0];
                                state_reg <= axpc_pkg::ST_CONST;
                            end else begin
                                spd_reg <= up_spd[SPD_W-1:0];
                            end
                        end
                        axpc_pkg::ST_CONST: begin
                            if (go_decel) begin
                                state_reg <= axpc_pkg::ST_DECEL;
                            end
                        end
                        axpc_pkg::ST_DECEL: begin
                            if (dn_spd[SPD_W] || dn_spd[SPD_W-1:0] <= init_reg[SPD_W-1:0]) begin
                                spd_reg <= init_reg[SPD_W-1:0];
                                if (cont_reg || stop_reg || lim_hit) begin
                                    state_reg <= axpc_pkg::ST_IDLE;
                                end
                            end else begin
                                spd_reg <= dn_spd[SPD_W-1:0];
                            end
                        end
                        default: state_reg <= axpc_pkg::ST_IDLE;
                    endcase
                end
            end else if (sclk_reg) begin
                phase_reg <= sum;
            end
            if (state_reg == axpc_pkg::ST_IDLE) begin
                lvl_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lpos_reg <= axpc_pkg::RST_ZERO;
        end else if (hit(axpc_pkg::OFS_LPOS)) begin
            lpos_reg <= merge(lpos_reg, wb_dat_i, wb_sel_i);
        end else if (tog && !lvl_reg) begin
            lpos_reg <= neg_reg ? lpos_reg - 32'sd1 : lpos_reg + 32'sd1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulse_pos_o <= 1'b0;
            pulse_neg_o <= 1'b0;
            dir_neg_o   <= 1'b0;
            driving_o   <= 1'b0;
        end else if (ce_i) begin
            pulse_pos_o <= lvl_reg & ~neg_reg;
            pulse_neg_o <= lvl_reg & neg_reg;
            dir_neg_o   <= neg_reg;
            driving_o   <= state_reg != axpc_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_reg <= axpc_pkg::RST_ZERO;
        end else if (rd_go) begin
            case (wb_adr_i)
                axpc_pkg::OFS_CMD:    rdat_reg <= {29'h0, stop_reg, state_reg};
                axpc_pkg::OFS_WR2:    rdat_reg <= wr2_reg;
                axpc_pkg::OFS_WR3:    rdat_reg <= wr3_reg;
                axpc_pkg::OFS_RANGE:  rdat_reg <= range_reg;
                axpc_pkg::OFS_SPEED:  rdat_reg <= speed_reg;
                axpc_pkg::OFS_INIT:   rdat_reg <= init_reg;
                axpc_pkg::OFS_ACC:    rdat_reg <= acc_reg;
                axpc_pkg::OFS_DEC:    rdat_reg <= dec_reg;
                axpc_pkg::OFS_PULSES: rdat_reg <= pulses_reg;
                axpc_pkg::OFS_DP:     rdat_reg <= dp_reg;
                axpc_pkg::OFS_LPOS:   rdat_reg <= lpos_reg;
                axpc_pkg::OFS_RPOS:   rdat_reg <= rpos_reg;
                axpc_pkg::OFS_CMPU:   rdat_reg <= cmpu_reg;
                axpc_pkg::OFS_CMPL:   rdat_reg <= cmpl_reg;
                axpc_pkg::OFS_RR1:    rdat_reg <= {30'h0, rr1_reg};
                axpc_pkg::OFS_RR2:    rdat_reg <= {30'h0, rr2_reg};
                default:              rdat_reg <= axpc_pkg::RST_ZERO;
            endcase
        end
    end
endmodule // axpc_axis_pulse_position_control
`default_nettype wire

/* rtl/axpc_pkg.sv */
// What this block does
// - Manual decel point equals output pulses minus pulses used decelerating.
// - Pulse period timed in system clocks, off by one at most.
// - Constant speed pulses have equal high and low time when the half period is whole system clocks, else they differ by one.
// - Low phase shorter when accelerating, longer when decelerating.
// - System clock is input clock divided by two.
// - Non-integer periods interleave two adjacent integer lengths.
// - Average pulse rate within 0.1% of requested speed.
// - Logical counter counts up per plus pulse, down per minus pulse.
// - Real counter counts encoder in quadrature or up/down form.
// - Both counters are signed 32-bit two's complement.
// - Host reads or writes counters any time, even while driving.
// - Two compare registers; source bit picks logical or real counter.
// - Above-upper flag set while counter exceeds upper compare.
// - Below-lower flag set while counter is under lower compare.
// - Soft limit enables stop by deceleration and set limit flag.
// - Upper limit flag clears once counter falls back below.
// - Compare registers writable any time.
// Purpose: constants and carriers for the single-axis pulse/position block
// Assumes: 32-bit classic Wishbone, byte addresses
// Notes:   register offsets are word aligned
`default_nettype none
package axpc_pkg;
    localparam int unsigned  CLK_HZ   = 10_000_000;
    localparam int unsigned  SCLK_DIV = 2;
    localparam int unsigned  SCLK_HZ  = CLK_HZ / SCLK_DIV;
    localparam longint unsigned MULT_NUM = 64'd8_000_000;
    localparam logic [7:0] OFS_CMD    = 8'h00;
    localparam logic [7:0] OFS_WR2    = 8'h04;
    localparam logic [7:0] OFS_WR3    = 8'h08;
    localparam logic [7:0] OFS_RANGE  = 8'h0c;
    localparam logic [7:0] OFS_SPEED  = 8'h10;
    localparam logic [7:0] OFS_INIT   = 8'h14;
    localparam logic [7:0] OFS_ACC    = 8'h18;
    localparam logic [7:0] OFS_DEC    = 8'h1c;
    localparam logic [7:0] OFS_PULSES = 8'h20;
    localparam logic [7:0] OFS_DP     = 8'h24;
    localparam logic [7:0] OFS_LPOS   = 8'h28;
    localparam logic [7:0] OFS_RPOS   = 8'h2c;
    localparam logic [7:0] OFS_CMPU   = 8'h30;
    localparam logic [7:0] OFS_CMPL   = 8'h34;
    localparam logic [7:0] OFS_RR1    = 8'h38;
    localparam logic [7:0] OFS_RR2    = 8'h3c;
    localparam logic [31:0] RST_RANGE = 32'h007a1200;
    localparam logic [31:0] RST_RATE  = 32'h00001f40;
    localparam logic [31:0] RST_ZERO  = 32'h00000000;
    localparam int unsigned CMD_START = 0;
    localparam int unsigned CMD_NEG   = 1;
    localparam int unsigned CMD_CONT  = 2;
    localparam int unsigned CMD_STOP  = 3;
    typedef struct packed {
        logic [24:0] rsv_hi;
        logic        enc_updown;
        logic        compare_source_select;
        logic [2:0]  rsv_lo;
        logic        lim_neg_en;
        logic        lim_pos_en;
    } axpc_wr2_t;
    typedef struct packed {
        logic [28:0] rsv;
        logic        s_curve;
        logic        sep_decel;
        logic        manual_decel;
    } axpc_wr3_t;
    typedef enum logic [1:0] {ST_IDLE, ST_ACCEL, ST_CONST, ST_DECEL} axpc_state_t;
endpackage
`default_nettype wire

/* testbench/axpc_drive_model.sv */
// Purpose: motor driver and encoder on the far side of the axis pins
// Assumes: one encoder step for each drive pulse
// Notes:   encoder lags the pulses by a cycle, like a real shaft
`default_nettype none
module axpc_drive_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic updown_i,
    input  wire logic pulse_pos_i,
    input  wire logic pulse_neg_i,
    output logic      enc_a_o,
    output logic      enc_b_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] phase_reg;
    logic       pos_d_reg;
    logic       neg_d_reg;
    always_ff @(posedge clk_i) begin
        pos_d_reg <= pulse_pos_i;
        neg_d_reg <= pulse_neg_i;
        if (rst_i) begin
            phase_reg <= 2'h0;
        end else if (pulse_pos_i && !pos_d_reg) begin
            phase_reg <= phase_reg + 2'h1;
        end else if (pulse_neg_i && !neg_d_reg) begin
            phase_reg <= phase_reg - 2'h1;
        end
    end
    assign enc_a_o = updown_i ? pos_d_reg : phase_reg[1] ^ phase_reg[0];
    assign enc_b_o = updown_i ? neg_d_reg : phase_reg[1];
endmodule // axpc_drive_model
`default_nettype wire

/* testbench/axpc_axis_asserts.sv */
// Purpose: port-level checks of the axis pulse outputs and bus answer
// Assumes: synchronous active-high reset
// Notes:   duty and period figures are measured by the bench instead
`default_nettype none
module axpc_axis_asserts #(
    parameter int unsigned SPD_W = 14,
    parameter int unsigned RNG_W = 24
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic pulse_pos_o,
    input wire logic pulse_neg_o,
    input wire logic dir_neg_o,
    input wire logic driving_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A pulse phase lasts one system clock, two input clocks, at least
    sequence pos_high_run;
        pulse_pos_o [*2];
    endsequence
    sequence neg_high_run;
        pulse_neg_o [*2];
    endsequence
    chk_ack_needs_req: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
        else $error("Ack without a request");
    chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("Ack held too long");
    chk_pos_high_min: assert property ($rose(pulse_pos_o) |-> pos_high_run)
        else $error("Plus pulse shorter than a system clock");
    chk_neg_high_min: assert property ($rose(pulse_neg_o) |-> neg_high_run)
        else $error("Minus pulse shorter than a system clock");
    chk_pos_low_min: assert property ($fell(pulse_pos_o) |-> !pulse_pos_o [*2])
        else $error("Plus low phase shorter than a system clock");
    chk_pulse_excl: assert property (!(pulse_pos_o && pulse_neg_o))
        else $error("Both pulse outputs high");
    chk_pos_dir: assert property (pulse_pos_o |-> !dir_neg_o && driving_o)
        else $error("Plus pulse with minus direction");
    chk_neg_dir: assert property (pulse_neg_o |-> dir_neg_o && driving_o)
        else $error("Minus pulse with plus direction");
    chk_dir_steady: assert property ((pulse_pos_o || pulse_neg_o) |-> $stable(dir_neg_o))
        else $error("Direction moved during a pulse");
endmodule // axpc_axis_asserts
bind axpc_axis_pulse_position_control axpc_axis_asserts #(.SPD_W(SPD_W), .RNG_W(RNG_W)) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .pulse_pos_o(pulse_pos_o), .pulse_neg_o(pulse_neg_o),
    .dir_neg_o(dir_neg_o), .driving_o(driving_o));
`default_nettype wire

/* testbench/axpc_axis_pulse_position_control_bench.sv */
// Purpose: self-checking bench of one axis
// Assumes: range 800000, so the multiple is ten
// Notes:   pulse phases are measured in input clocks
`default_nettype none
module axpc_axis_pulse_position_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam longint unsigned RNG = 800000;
    logic        clk_i    = 1'b0;
    logic        rst_i    = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic        updown   = 1'b0;
    logic [31:0] wb_dat_o;
    logic [31:0] q;
    logic        wb_ack_o;
    logic        enc_a;
    logic        enc_b;
    logic        pulse_pos_o;
    logic        pulse_neg_o;
    logic        dir_neg_o;
    logic        driving_o;
    int          fail_count  = 0;
    int          comparisons = 0;
    int          hq[$];
    int          lq[$];
    always #50 clk_i = ~clk_i;
    axpc_axis_pulse_position_control dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .enc_a_i(enc_a), .enc_b_i(enc_b), .pulse_pos_o(pulse_pos_o),
        .pulse_neg_o(pulse_neg_o), .dir_neg_o(dir_neg_o), .driving_o(driving_o));
    axpc_drive_model drv_u (.clk_i(clk_i), .rst_i(rst_i), .updown_i(updown),
        .pulse_pos_i(pulse_pos_o), .pulse_neg_i(pulse_neg_o), .enc_a_o(enc_a), .enc_b_o(enc_b));
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Entered just after a rising edge; waits for ack under a bound
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        cmp32(32'(n < 40), 32'h1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        cmp32(q & m, e);
    endtask
    task automatic setup(input logic [31:0] sv, input logic [31:0] v, input logic [31:0] n);
        wr(axpc_pkg::OFS_RANGE, 32'(RNG));
        wr(axpc_pkg::OFS_INIT, sv);
        wr(axpc_pkg::OFS_SPEED, v);
        wr(axpc_pkg::OFS_PULSES, n);
        wr(axpc_pkg::OFS_LPOS, 32'h0);
        wr(axpc_pkg::OFS_RPOS, 32'h0);
    endtask
    // Records high and low run lengths of every pulse until driving ends
    task automatic run(input logic [31:0] cmd);
        int c;
        int len;
        logic last;
        logic p;
        hq.delete();
        lq.delete();
        c = 0;
        len = 0;
        last = 1'b0;
        wr(axpc_pkg::OFS_CMD, cmd);
        while ((driving_o === 1'b1 || c < 8) && c < 60000) begin
            @(posedge clk_i);
            c++;
            p = pulse_pos_o | pulse_neg_o;
            if (p === last) begin
                len++;
            end else begin
                if (last) hq.push_back(len);
                else if (hq.size() > 0) lq.push_back(len);
                len = 1;
            end
            last = p;
        end
        if (last) hq.push_back(len);
        cmp32(32'(c < 60000), 32'h1);
    endtask
    task automatic t_compare();
        wr(axpc_pkg::OFS_WR2, 32'h0);
        wr(axpc_pkg::OFS_LPOS, 32'h5);
        wr(axpc_pkg::OFS_RPOS, 32'hfffffffb);
        wr(axpc_pkg::OFS_CMPU, 32'h0);
        wr(axpc_pkg::OFS_CMPL, 32'h0);
        rd(axpc_pkg::OFS_LPOS, 32'hffffffff, 32'h5);
        rd(axpc_pkg::OFS_RR1, 32'h3, 32'h1);
        wr(axpc_pkg::OFS_WR2, 32'h20);
        rd(axpc_pkg::OFS_RR1, 32'h3, 32'h2);
        wr(axpc_pkg::OFS_CMPU, 32'h7fffffff);
        wr(axpc_pkg::OFS_CMPL, 32'hfffffff0);
        rd(axpc_pkg::OFS_RR1, 32'h3, 32'h0);
        wb(1'b0, 8'h40, 32'h0);
    endtask
    task automatic t_const();
        longint half;
        half = axpc_pkg::CLK_HZ * RNG / 1250 / axpc_pkg::MULT_NUM / 2;
        wr(axpc_pkg::OFS_WR2, 32'h0);
        wr(axpc_pkg::OFS_WR3, 32'h0);
        setup(32'd1250, 32'd1250, 32'd6);
        run(32'h1);
        cmp32(32'(hq.size()), 32'd6);
        foreach (hq[i]) cmp32(32'(hq[i]), 32'(half));
        foreach (lq[i]) cmp32(32'(lq[i]), 32'(hq[i]));
        rd(axpc_pkg::OFS_LPOS, 32'hffffffff, 32'd6);
        rd(axpc_pkg::OFS_RPOS, 32'h80000000, 32'h0);
        cmp32(32'(q != 32'h0), 32'h1);
    endtask
    task automatic t_frac();
        longint sum;
        int per;
        int lo;
        sum = 0;
        lo = int'(axpc_pkg::SCLK_HZ / 13000 * axpc_pkg::SCLK_DIV);
        updown <= 1'b1;
        wr(axpc_pkg::OFS_WR2, 32'h40);
        setup(32'd1300, 32'd1300, 32'd27);
        run(32'h3);
        cmp32(32'(hq.size()), 32'd27);
        foreach (lq[i]) begin
            per = hq[i] + lq[i];
            sum += per;
            cmp32(32'(per == lo || per == lo + axpc_pkg::SCLK_DIV), 32'h1);
        end
        cmp32(32'(sum * 13000000 > lq.size() * 999 * axpc_pkg::CLK_HZ
            && sum * 13000000 < lq.size() * 1001 * axpc_pkg::CLK_HZ), 32'h1);
        rd(axpc_pkg::OFS_LPOS, 32'hffffffff, 32'hffffffe5);
        rd(axpc_pkg::OFS_RPOS, 32'h80000000, 32'h80000000);
    endtask
    task automatic t_ramp();
        int acc;
        int dec;
        int early;
        acc = 0;
        dec = 0;
        early = 0;
        updown <= 1'b0;
        wr(axpc_pkg::OFS_WR2, 32'h0);
        wr(axpc_pkg::OFS_WR3, 32'h7);
        wr(axpc_pkg::OFS_ACC, 32'd8000);
        wr(axpc_pkg::OFS_DEC, 32'd8000);
        wr(axpc_pkg::OFS_DP, 32'd18);
        setup(32'd625, 32'd1250, 32'd24);
        run(32'h1);
        cmp32(32'(hq.size()), 32'd24);
        foreach (lq[i]) begin
            if (i < 17 && lq[i] < hq[i]) acc++;
            if (i < 17 && lq[i] > hq[i]) early++;
            if (i >= 18 && lq[i] > hq[i]) dec++;
        end
        cmp32(32'(acc > 0 && dec > 0), 32'h1);
        cmp32(32'(early), 32'h0);
    endtask
    task automatic t_limit();
        wr(axpc_pkg::OFS_WR3, 32'h0);
        wr(axpc_pkg::OFS_CMPU, 32'h4);
        wr(axpc_pkg::OFS_CMPL, 32'hfffffff0);
        wr(axpc_pkg::OFS_WR2, 32'h3);
        setup(32'd1250, 32'd1250, 32'd40);
        run(32'h1);
        cmp32(32'(hq.size() > 4 && hq.size() < 40), 32'h1);
        rd(axpc_pkg::OFS_RR2, 32'h1, 32'h1);
        rd(axpc_pkg::OFS_RR1, 32'h3, 32'h1);
        wr(axpc_pkg::OFS_LPOS, 32'h2);
        rd(axpc_pkg::OFS_RR2, 32'h1, 32'h0);
    endtask
    task automatic give_verdict();
        if (fail_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_compare();
        t_const();
        t_frac();
        t_ramp();
        t_limit();
        give_verdict();
    end
    // The whole run needs about 60000 cycles; 100000 means a hang
    initial begin
        #10_000_000;
        fail_count++;
        give_verdict();
    end
endmodule // axpc_axis_pulse_position_control_bench
`default_nettype wire
